// ==== uld_ctrl.sv ====
/*
  UTMI-side controller: drives operating mode, transceiver and termination
  selects and transmit valid, watches line state for reset or suspend.
  Assumes a UTMI transceiver on the far pins and software on AXI4-Lite.
*/
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "uld_consts.svh"
module uld_ctrl #(
  parameter int IDLE_MIN_CYC  = `ULD_NS_DN(`ULD_T_IDLE_NS),
  parameter int REV_MAX_CYC   = `ULD_NS_DN(`ULD_T_REVMAX_NS),
  parameter int SMP_MIN_CYC   = `ULD_NS_UP(`ULD_T_SMPMIN_NS),
  parameter int SMP_MAX_CYC   = `ULD_NS_DN(`ULD_T_SMPMAX_NS),
  parameter int RES_MIN_CYC   = `ULD_NS_UP(`ULD_T_RESMIN_NS),
  parameter int SUS_MAX_CYC   = `ULD_NS_DN(`ULD_T_SUSMAX_NS),
  parameter int RESUME_BYTES  = `ULD_RESUME_BYTES
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // AXI4-Lite slave
  input  wire logic [`ULD_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`ULD_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // UTMI transceiver pins
  output uld_pkg::uld_utmi_out_s      utmi_o,
  input  wire uld_pkg::uld_utmi_in_s  utmi_i,
  output logic                        suspend_n
);
  import uld_pkg::*;

  localparam int CNT_W = 18;
  localparam logic [CNT_W-1:0] C_IDLE   = CNT_W'(IDLE_MIN_CYC);
  localparam logic [CNT_W-1:0] C_REVMAX = CNT_W'(REV_MAX_CYC);
  localparam logic [CNT_W-1:0] C_SMP    = CNT_W'(SMP_MIN_CYC + 2);
  localparam logic [CNT_W-1:0] C_RESMIN = CNT_W'(RES_MIN_CYC);
  localparam logic [CNT_W-1:0] C_SUSMAX = CNT_W'(SUS_MAX_CYC);
  localparam logic [CNT_W-1:0] C_SAT    = '1;
  localparam logic [6:0]       C_FSRST  = 7'(`ULD_NS_UP(`ULD_T_FSRST_NS));
  localparam logic [3:0]       C_GUARD  = 4'(`ULD_GUARD_CYC);
  localparam logic [15:0]      C_RESB   = 16'(RESUME_BYTES - 1);

  generate
    if (IDLE_MIN_CYC >= REV_MAX_CYC - 1 || SMP_MIN_CYC + 2 > SMP_MAX_CYC ||
        SUS_MAX_CYC >= 2**CNT_W - 1 || RES_MIN_CYC > SUS_MAX_CYC ||
        RESUME_BYTES < 1 || RESUME_BYTES > 65536) begin : g_bad_param
      $error("uld_ctrl: timing parameters out of range");
    end
  endgenerate

  // Register front end
  logic                   wr_pulse, wr_hit, rd_hit;
  logic [`ULD_ADDR_W-1:0] wr_addr, rd_addr;
  logic [31:0]            wr_data, rd_data, wmask;
  logic [3:0]             wr_strb;

  uld_axil #(.ADDR_W(`ULD_ADDR_W)) u_axil (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .wr_hit(wr_hit), .rd_addr(rd_addr), .rd_hit(rd_hit), .rd_data(rd_data)
  );

  assign wmask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_hit = wr_addr inside {`ULD_OFF_CTRL, `ULD_OFF_TXDATA, `ULD_OFF_STATUS, `ULD_OFF_EVENT};
  assign rd_hit = rd_addr inside {`ULD_OFF_CTRL, `ULD_OFF_TXDATA, `ULD_OFF_STATUS, `ULD_OFF_EVENT};

  // Pin synchroniser; a change counts once stages two and three agree
  uld_utmi_in_s pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r  <= '0;
    end else begin
      pin_s1_r <= utmi_i;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_q_r <= pin_s3_r;
      end
    end
  end

  // Line codes shared by HS and FS decoding
  logic ls_se0, ls_j;
  assign ls_se0 = pin_q_r.linestate == 2'h0;
  assign ls_j   = pin_q_r.linestate == 2'h1;

  // Software registers
  logic [31:0] ctrl_r;
  logic [7:0]  txd_r;
  logic [3:0]  evt_r, evt_set;
  logic        resume_pend_r, resume_go;
  uld_test_e   tm;
  uld_state_e  st_r, st_nxt;

  assign tm = uld_test_e'(ctrl_r[`ULD_F_TEST]);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_r <= `ULD_CTRL_RST;
      txd_r  <= 8'h00;
    end else if (wr_pulse && wr_addr == `ULD_OFF_CTRL) begin
      ctrl_r <= ((ctrl_r & ~wmask) | (wr_data & wmask)) & `ULD_CTRL_MASK;
    end else if (wr_pulse && wr_addr == `ULD_OFF_TXDATA && wr_strb[0]) begin
      txd_r <= wr_data[7:0];
    end
  end

  // Resume request latched until started; the start wins over a new write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      resume_pend_r <= 1'b0;
    end else if (resume_go) begin
      resume_pend_r <= 1'b0;
    end else if (wr_pulse && wr_addr == `ULD_OFF_CTRL && wr_strb[1] && wr_data[`ULD_F_RESUME]) begin
      resume_pend_r <= 1'b1;
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evt_r <= 4'h0;
    end else begin
      evt_r <= (evt_r & ~((wr_pulse && wr_addr == `ULD_OFF_EVENT && wr_strb[0]) ? wr_data[3:0] : 4'h0))
               | evt_set;
    end
  end

  always_comb begin
    unique case (rd_addr)
      `ULD_OFF_CTRL:   rd_data = ctrl_r;
      `ULD_OFF_TXDATA: rd_data = {24'h000000, txd_r};
      `ULD_OFF_STATUS: rd_data = {21'h000000, utmi_o.txvalid, utmi_o.termsel, utmi_o.xcvrsel,
                                  utmi_o.opmode, !suspend_n, st_r, pin_q_r.linestate};
      `ULD_OFF_EVENT:  rd_data = {28'h0000000, evt_r};
      default:         rd_data = 32'h00000000;
    endcase
  end

  // Wanted line mode from state, test selection and software
  logic [1:0] des_op;
  logic       des_x, des_t, quiet, ap_match;

  always_comb begin
    des_op = (ctrl_r[`ULD_F_OP] == 2'h3) ? 2'h0 : ctrl_r[`ULD_F_OP];
    des_x  = ctrl_r[`ULD_F_XCVR];
    des_t  = ctrl_r[`ULD_F_TERM];
    if (st_r inside {ST_REVERT, ST_SUSPEND, ST_RESET, ST_RESUME}) begin
      des_op = (st_r == ST_RESUME) ? 2'h2 : 2'h0;
      des_x  = 1'b1;
      des_t  = 1'b1;
    end else if (tm inside {TM_SE0_NAK, TM_J, TM_K, TM_PACKET}) begin
      des_op = (tm inside {TM_J, TM_K}) ? 2'h2 : 2'h0;
      des_x  = 1'b0;
      des_t  = 1'b0;
    end
  end

  // Selects move only with transmitter and receiver idle
  assign quiet    = !utmi_o.txvalid && !pin_q_r.rxactive;
  assign ap_match = {utmi_o.opmode, utmi_o.xcvrsel, utmi_o.termsel} == {des_op, des_x, des_t};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      utmi_o.opmode  <= 2'h0;
      utmi_o.xcvrsel <= 1'b1;
      utmi_o.termsel <= 1'b1;
    end else if (quiet) begin
      utmi_o.opmode  <= des_op;
      utmi_o.xcvrsel <= des_x;
      utmi_o.termsel <= des_t;
    end
  end

  // Guard between entering mode 10 and raising transmit valid
  logic [3:0] guard_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      guard_r <= 4'h0;
    end else if (quiet && des_op != utmi_o.opmode) begin
      guard_r <= 4'h0;
    end else if (guard_r != C_GUARD) begin
      guard_r <= guard_r + 4'h1;
    end
  end

  // Inactivity timer since the last bus activity
  logic [CNT_W-1:0] idle_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      idle_r <= '0;
    end else if (st_r == ST_HS_MON && !ls_se0) begin
      idle_r <= '0;
    end else if (st_r inside {ST_HS_MON, ST_REVERT, ST_SUSPEND}) begin
      idle_r <= (idle_r == C_SAT) ? idle_r : idle_r + 1'b1;
    end else begin
      idle_r <= '0;
    end
  end

  logic [CNT_W-1:0] rev_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rev_r <= '0;
    end else begin
      rev_r <= (st_r == ST_REVERT) ? rev_r + 1'b1 : '0;
    end
  end

  // FS long SE0 detection; never armed in HS, where idle is SE0
  logic [6:0] se0_r;
  logic       fs_se0;
  assign fs_se0 = st_r == ST_MANUAL && utmi_o.xcvrsel && ls_se0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      se0_r <= 7'h00;
    end else if (!fs_se0) begin
      se0_r <= 7'h00;
    end else if (se0_r != C_FSRST) begin
      se0_r <= se0_r + 7'h01;
    end
  end

  // Resume transmission of K bytes
  logic [15:0] resb_r;
  logic        res_done;
  assign res_done = utmi_o.txvalid && pin_q_r.txready && resb_r == C_RESB;

  always_ff @(posedge mclk) begin
    if (!rst_n || st_r != ST_RESUME) begin
      resb_r <= 16'h0000;
    end else if (utmi_o.txvalid && pin_q_r.txready) begin
      resb_r <= resb_r + 16'h0001;
    end
  end

  // Reset or suspend discrimination
  logic hs_ready;
  assign hs_ready  = ctrl_r[`ULD_F_AUTO] && !utmi_o.xcvrsel && !utmi_o.termsel && tm == TM_NONE;
  assign resume_go = st_r == ST_SUSPEND && ls_j && resume_pend_r && idle_r >= C_RESMIN;

  always_comb begin
    st_nxt  = st_r;
    evt_set = 4'h0;
    evt_set[`ULD_EVT_FSRST] = fs_se0 && se0_r == C_FSRST - 7'h01;
    unique case (st_r)
      ST_MANUAL:  if (hs_ready) st_nxt = ST_HS_MON;
      ST_HS_MON: begin
        if (!hs_ready) begin
          st_nxt = ST_MANUAL;
        end else if (idle_r > C_IDLE) begin
          st_nxt = ST_REVERT;
        end
      end
      ST_REVERT: begin
        if (rev_r == C_SMP) begin
          if (ls_se0) begin
            st_nxt = ST_RESET;
            evt_set[`ULD_EVT_HSRST] = 1'b1;
          end else if (ls_j) begin
            st_nxt = ST_SUSPEND;
            evt_set[`ULD_EVT_SUSP] = 1'b1;
          end else begin
            st_nxt = ST_MANUAL;
          end
        end
      end
      ST_SUSPEND: begin
        if (!ls_j) begin
          st_nxt = ST_MANUAL;
          evt_set[`ULD_EVT_WAKE] = 1'b1;
        end else if (resume_go) begin
          st_nxt = ST_RESUME;
        end
      end
      ST_RESUME:  if (res_done) st_nxt = ST_MANUAL;
      ST_RESET:   if (!ctrl_r[`ULD_F_AUTO]) st_nxt = ST_MANUAL;
      default:    st_nxt = ST_MANUAL;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r <= ST_MANUAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Suspend taken right at the J sample, well inside the deadline
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      suspend_n <= 1'b1;
    end else begin
      suspend_n <= st_nxt != ST_SUSPEND;
    end
  end

  // Transmit valid and data
  logic tx_want;

  always_comb begin
    tx_want = 1'b0;
    if (st_r == ST_RESUME) begin
      tx_want = !res_done;
    end else if (st_r inside {ST_MANUAL, ST_HS_MON}) begin
      tx_want = (tm inside {TM_J, TM_K}) ||
                (tm inside {TM_NONE, TM_PACKET} && ctrl_r[`ULD_F_TXEN]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      utmi_o.txvalid <= 1'b0;
      utmi_o.txdata  <= 8'h00;
    end else begin
      utmi_o.txvalid <= tx_want && ap_match && (utmi_o.opmode != 2'h2 || guard_r == C_GUARD);
      utmi_o.txdata  <= (tm == TM_J && st_r != ST_RESUME) ? 8'hFF :
                        (tm == TM_K || st_r == ST_RESUME) ? 8'h00 : txd_r;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_r5; st_r == ST_HS_MON && ls_se0 && idle_r < C_IDLE |=> idle_r == $past(idle_r) + 1'b1; endproperty
  a_r5: assert property (p_r5) else $error("idle timer did not advance");
  property p_r22; st_r == ST_HS_MON && !ls_se0 |=> idle_r == '0; endproperty
  a_r22: assert property (p_r22) else $error("idle timer not restarted");
  property p_r6; utmi_o.opmode != 2'h3; endproperty
  a_r6: assert property (p_r6) else $error("reserved mode driven");
  property p_r9; $changed(utmi_o.opmode) |-> $past(quiet); endproperty
  a_r9: assert property (p_r9) else $error("mode changed while busy");
  property p_r13; $changed({utmi_o.xcvrsel, utmi_o.termsel}) |-> !$past(utmi_o.txvalid); endproperty
  a_r13: assert property (p_r13) else $error("select changed while transmitting");
  property p_r10; $rose(utmi_o.txvalid) && utmi_o.opmode == 2'h2 |-> $past(utmi_o.opmode, 3) == 2'h2; endproperty
  a_r10: assert property (p_r10) else $error("transmit valid too soon after mode 10");
  property p_r14; st_r == ST_MANUAL && tm == TM_K && quiet ##1 tm == TM_K
    |-> utmi_o.opmode == 2'h2 && !utmi_o.xcvrsel && !utmi_o.termsel; endproperty
  a_r14: assert property (p_r14) else $error("test K setup wrong");
  property p_r15; fs_se0 && se0_r == C_FSRST - 7'h01 |=> evt_r[`ULD_EVT_FSRST]; endproperty
  a_r15: assert property (p_r15) else $error("FS reset not flagged");
  property p_r16; !utmi_o.xcvrsel |=> !$rose(evt_r[`ULD_EVT_FSRST]); endproperty
  a_r16: assert property (p_r16) else $error("short SE0 treated as reset in HS");
  property p_r17; $rose(st_r == ST_REVERT) |-> idle_r > C_IDLE && idle_r < C_REVMAX ##1 utmi_o.xcvrsel; endproperty
  a_r17: assert property (p_r17) else $error("revert outside window");
  property p_r18; st_r == ST_REVERT && rev_r == C_SMP && ls_se0 |=> st_r == ST_RESET && evt_r[`ULD_EVT_HSRST];
  endproperty
  a_r18: assert property (p_r18) else $error("driven reset missed");
  property p_r19; st_r == ST_REVERT && rev_r == C_SMP && ls_j |=> !suspend_n && st_r == ST_SUSPEND; endproperty
  a_r19: assert property (p_r19) else $error("suspend missed");
  property p_r20; $fell(suspend_n) |-> idle_r <= C_SUSMAX; endproperty
  a_r20: assert property (p_r20) else $error("suspend too late");
  property p_r21; $rose(st_r == ST_RESUME) |-> $past(idle_r) >= C_RESMIN; endproperty
  a_r21: assert property (p_r21) else $error("resume too early");

endmodule : uld_ctrl

// ==== uld_consts.svh ====
/*
  Offsets, field positions, reset values and timing figures of the
  line-state monitor and mode controller. Assumes a 25 MHz system clock.
*/
`ifndef ULD_CONSTS_SVH
`define ULD_CONSTS_SVH

`define ULD_ADDR_W         4
`define ULD_OFF_CTRL       4'h0
`define ULD_OFF_TXDATA     4'h4
`define ULD_OFF_STATUS     4'h8
`define ULD_OFF_EVENT      4'hC

`define ULD_CTRL_RST       32'h0000000C
`define ULD_CTRL_MASK      32'h000003FF
`define ULD_F_OP           1:0
`define ULD_F_XCVR         2
`define ULD_F_TERM         3
`define ULD_F_TXEN         4
`define ULD_F_AUTO         5
`define ULD_F_TEST         8:6
`define ULD_F_RESUME       9

`define ULD_EVT_HSRST      0
`define ULD_EVT_SUSP       1
`define ULD_EVT_FSRST      2
`define ULD_EVT_WAKE       3

`define ULD_CLK_KHZ        25000
`define ULD_PHY_KHZ        60000
`define ULD_PHY_GUARD_CYC  5
`define ULD_T_IDLE_NS      3000000
`define ULD_T_REVMAX_NS    3125000
`define ULD_T_SMPMIN_NS    100000
`define ULD_T_SMPMAX_NS    875000
`define ULD_T_RESMIN_NS    5000000
`define ULD_T_SUSMAX_NS    10000000
`define ULD_T_FSRST_NS     2500
`define ULD_RESUME_BYTES   1500

`define ULD_NS_UP(ns) int'((64'(ns) * 64'(`ULD_CLK_KHZ) + 64'd999999) / 64'd1000000)
`define ULD_NS_DN(ns) int'((64'(ns) * 64'(`ULD_CLK_KHZ)) / 64'd1000000)
`define ULD_GUARD_CYC int'((`ULD_PHY_GUARD_CYC * `ULD_CLK_KHZ + `ULD_PHY_KHZ - 1) / `ULD_PHY_KHZ)

`endif

// ==== uld_pkg.sv ====
/*
  Types of the line-state monitor and mode controller: UTMI carriers,
  controller states and test-mode selections. Assumes nothing else.
*/
package uld_pkg;

  typedef struct packed {
    logic [1:0] opmode;
    logic       xcvrsel;
    logic       termsel;
    logic       txvalid;
    logic [7:0] txdata;
  } uld_utmi_out_s;

  typedef struct packed {
    logic [1:0] linestate;
    logic       rxactive;
    logic       txready;
  } uld_utmi_in_s;

  typedef enum logic [2:0] {
    ST_MANUAL, ST_HS_MON, ST_REVERT, ST_SUSPEND, ST_RESUME, ST_RESET
  } uld_state_e;

  typedef enum logic [2:0] {
    TM_NONE, TM_SE0_NAK, TM_J, TM_K, TM_PACKET
  } uld_test_e;

endpackage : uld_pkg

// ==== uld_axil.sv ====
/*
  AXI4-Lite slave front end: one write and one read at a time.
  Assumes the owner decodes the address and returns read data combinationally.
*/
`timescale 1ns/1ns
module uld_axil #(
  parameter int ADDR_W = 4
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Register side
  output logic                   wr_pulse,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_hit,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic              rd_hit,
  input  wire logic [31:0]       rd_data
);

  logic aw_have_r;
  logic w_have_r;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_pulse      = aw_have_r && w_have_r;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr       = s_axi_araddr;

  // Address and data may arrive in either order
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= 32'h00000000;
      wr_strb   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        wr_addr   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wr_data  <= s_axi_wdata;
        wr_strb  <= s_axi_wstrb;
      end
      if (wr_pulse) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_pulse) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_hit ? rd_data : 32'h00000000;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : uld_axil

// ==== uld_phy_model.sv ====
/*
  Behavioural transceiver model: line-state coding and transmit ready.
  Assumes the bench gives the cable state as an FS line code on bus_fs.
*/
`timescale 1ns/1ns
module uld_phy_model (
  // Clock
  input  wire logic                  mclk,
  // Controller side
  input  wire uld_pkg::uld_utmi_out_s utmi_o,
  output uld_pkg::uld_utmi_in_s      utmi_i,
  // Cable state, 00 SE0, 01 J, 10 K, 11 SE1
  input  wire logic [1:0]            bus_fs
);
  import uld_pkg::*;
  logic sq;
  logic dif;
  // Idle cable reads as squelch at HS thresholds
  assign sq  = (bus_fs == 2'b00);
  assign dif = (bus_fs == 2'b01);
  always_ff @(posedge mclk) begin
    if (utmi_o.xcvrsel) utmi_i.linestate <= bus_fs;
    else if (!utmi_o.termsel) utmi_i.linestate <= sq ? 2'b00 : 2'b01;
    else utmi_i.linestate <= sq ? 2'b00 : (dif ? 2'b01 : 2'b10);
    // Non-driving mode never consumes bytes
    utmi_i.txready  <= utmi_o.txvalid && utmi_o.opmode != 2'b01;
    utmi_i.rxactive <= 1'b0;
  end
endmodule : uld_phy_model

// ==== uld_ctrl_test.sv ====
/*
  Self-checking bench of the controller: AXI4-Lite tasks, test modes,
  HS reset and suspend discrimination. Assumes the transceiver model.
*/
`timescale 1ns/1ns
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %0t %s", $time, m); end end
`define WAITF(c, n) begin for (wn = 0; wn < (n) && !(c); wn++) @(negedge mclk); if (!(c)) tmo(); end
module uld_ctrl_test;
  import uld_pkg::*;
  logic          mclk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, suspend_n;
  logic [3:0]    s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rv;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rr, bus_fs;
  uld_utmi_out_s utmi_o;
  uld_utmi_in_s  utmi_i;
  int            errors, checked, wn, c, o, v;
  // Short counts keep the run brief
  uld_ctrl #(.IDLE_MIN_CYC(100), .REV_MAX_CYC(110), .SMP_MIN_CYC(20), .SMP_MAX_CYC(40),
    .RES_MIN_CYC(200), .SUS_MAX_CYC(400), .RESUME_BYTES(4)) DUT (.mclk, .rst_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .utmi_o, .utmi_i, .suspend_n);
  uld_phy_model PHY (.mclk, .utmi_o, .utmi_i, .bus_fs);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  task tmo;
    errors++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask : tmo
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ra, rw, ok;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (40) begin
      @(negedge mclk);
      ra = s_axi_awready;
      rw = s_axi_wready;
      ok = s_axi_bvalid;
      @(posedge mclk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (ok) begin
        s_axi_bready <= !ok;
        return;
      end
    end
    tmo();
  endtask : wr
  task automatic rd(input logic [3:0] a);
    logic ra, ok;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (40) begin
      @(negedge mclk);
      ra = s_axi_arready;
      ok = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge mclk);
      if (ra) s_axi_arvalid <= 1'b0;
      if (ok) begin
        s_axi_rready <= !ok;
        return;
      end
    end
    tmo();
  endtask : rd
  initial begin
    repeat (20000) @(posedge mclk);
    tmo();
  end
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    bus_fs = 2'b01;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    `CHK(utmi_o, 13'h0600, "reset pins")
    rd(4'h0);
    `CHK(rv, 32'h0000000C, "reset ctrl")
    rd(4'h2);
    `CHK(rr, 2'h2, "unmapped resp")
    wr(4'h4, 32'hA5, 4'hE);
    rd(4'h4);
    `CHK(rv, 32'h0, "strobe lane off")
    wr(4'h4, 32'h5A, 4'h1);
    rd(4'h4);
    `CHK(rv, 32'h5A, "strobe lane on")
    $display("test reset done");
    for (int tm = 1; tm < 5; tm++) begin
      fork
        wr(4'h0, 32'(tm) << 6);
        begin
          o = -1;
          v = -1;
          for (c = 0; c < 40; c++) begin
            @(negedge mclk);
            if (o < 0 && utmi_o.opmode === 2'b10) o = c;
            if (v < 0 && utmi_o.txvalid === 1'b1) v = c;
          end
        end
      join
      `CHK({utmi_o.xcvrsel, utmi_o.termsel}, 2'b00, "test selects")
      `CHK(utmi_o.opmode, (tm == 2 || tm == 3) ? 2'b10 : 2'b00, "test mode")
      if (tm < 4) `CHK(utmi_o.txvalid, tm > 1, "test valid")
      if (tm == 2 || tm == 3) begin
        `CHK(v - o >= 3, 1'b1, "mode guard")
        `CHK(utmi_o.txdata, tm == 2 ? 8'hFF : 8'h00, "test data")
      end
      wr(4'h0, 32'hC);
      `WAITF(utmi_o.txvalid === 1'b0 && utmi_o.xcvrsel === 1'b1, 40)
    end
    $display("test modes done");
    for (int k = 0; k < 2; k++) begin
      bus_fs <= 2'b00;
      wr(4'h0, 32'h20);
      `WAITF(utmi_o.xcvrsel === 1'b0, 20)
      repeat (60) @(posedge mclk);
      bus_fs <= 2'b01;
      repeat (3) @(posedge mclk);
      bus_fs <= 2'b00;
      for (c = 0; c < 130 && utmi_o.xcvrsel !== 1'b1; c++) @(negedge mclk);
      `CHK(c >= 100 && c <= 120, 1'b1, "revert time")
      `CHK(utmi_o.termsel, 1'b1, "revert term")
      bus_fs <= k ? 2'b01 : 2'b00;
      repeat (60) @(posedge mclk);
      rd(4'hC);
      `CHK(rv, k ? 32'h2 : 32'h1, "found event")
      rd(4'h8);
      `CHK(rv[4:2], k ? 3'd3 : 3'd5, "found state")
      `CHK(suspend_n, k ? 1'b0 : 1'b1, "suspend pin")
      bus_fs <= 2'b10;
      wr(4'hC, 32'h3);
      wr(4'h0, 32'hC);
      `WAITF(suspend_n === 1'b1, 30)
      rd(4'hC);
      `CHK(rv, k ? 32'h8 : 32'h0, "wake event")
      wr(4'hC, 32'hF);
      $display("detect test %0d done", k);
    end
    report_and_stop();
  end
endmodule : uld_ctrl_test
